/* File: verilog/rx_status_cfg.svh */
// Register offsets, field positions, reset values and counts for the receive-port status bank.
// How it works
// RULE_01 - Self-test starts or stops from the enable bit in the self-test configuration.
// RULE_02 - Self-test configuration picks pixel clock or internal oscillator as test clock.
// RULE_03 - An active self-test raises the enable indication sent over the back channel.
// RULE_04 - The far serializer answers with a continuous pseudo-random stream at full speed; the model sends NB bits per enable, every third cycle if slow.
// RULE_05 - The far serializer checks every back-channel frame CRC and tracks errors; the model only counts frames whose enable is not a clean level.
// RULE_06 - Incoming pseudo-random bits are predicted and mismatches are flagged as errors.
// RULE_07 - Each receive port counts its self-test errors in a readable counter.
// RULE_08 - During self-test the pixel clock output comes from the internal link clock.
// RULE_09 - Range 0x4c-0x7f is paged: read select bits 5:4, write enables bits 1:0.
// RULE_10 - Test-mode range 0xd0-0xdf is duplicated per port under the same paging.
// RULE_11 - Both the local target port and the control channel reach every register.
// RULE_12 - Read-to-clear fields return their value and are cleared by that read.
// RULE_13 - Self-clearing bits drop to zero once their action has been launched.
// RULE_14 - Latched bits catch an event and hold it until software reads them.
// RULE_15 - Strap fields take their start value from the sampled configuration pin.
// RULE_16 - Primary status: port number 7:6, then crc, lock change, sequence, parity, pass, lock.
// RULE_17 - Secondary status: encode error bit 5, frequency stable bit 2, clock missing bit 1.
// RULE_18 - Low source register: parity 2, pass 1, lock 0; cleared by secondary read.
// RULE_19 - High source register: encode 2, sequence 1, crc 0; cleared like the low one.
// RULE_20 - Interrupt pin asserts only with port status, port enable and global enable.
// RULE_21 - Global status: bit 7 global, bit 1 port 1 pending, bit 0 port 0 pending.
// RULE_22 - With both write enables set a paged write updates both ports.
`ifndef RX_STATUS_CFG_SVH
`define RX_STATUS_CFG_SVH
`define ADDR_IRQ_CTRL 8'h23
`define ADDR_IRQ_STATUS 8'h24
`define ADDR_PAGE_SEL 8'h4c
`define ADDR_STS_PRI 8'h4d
`define ADDR_STS_SEC 8'h4e
`define ADDR_ERR_CNT 8'h57
`define ADDR_ST_CFG 8'hb3
`define ADDR_TEST_MODE 8'hd0
`define ADDR_ISR_HI 8'hda
`define ADDR_ISR_LO 8'hdb
`define PAGED_LO 8'h4c
`define PAGED_HI 8'h7f
`define PAGE_SEL_RESET 8'h01
`define IRQ_CTRL_RESET 8'h00
`define ST_CFG_RESET 8'h00
`define ST_EN_BIT 0
`define ST_OSC_BIT 1
`define ST_CLR_BIT 2
`define IRQ_GLOBAL_BIT 7
`define PRBS_PRIME_BITS 3'd7
`define ERR_CNT_MAX 8'hff
`define STRAP_FILL_EDGES 2'd3
`endif

/* File: verilog/rx_status_pkg.sv */
// Types shared by the receive-port status bank and its users.
package rx_status_pkg;
    typedef logic [7:0] byte_t;
    // One register access request from either access path.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
    // Answer to a register access.
    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } reg_rsp_s;
    // Live state and one-cycle events from one receive port.
    typedef struct packed {
        logic lock;
        logic pass;
        logic parity_err;
        logic crc_err;
        logic seq_err;
        logic enc_err;
        logic frequency_stable_flag;
        logic clk_missing;
        logic rx_bit;
        logic rx_bit_valid;
    } port_in_s;
endpackage

/* File: verilog/rx_status_regs.sv */
// Receive-port status, interrupt source, paging and link self-test register bank.
`timescale 1ns/1ps
`include "rx_status_cfg.svh"
module rx_port_status_bist_regs
    import rx_status_pkg::*;
(
    input wire logic clock, // 40 MHz system clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire reg_req_s loc_req, // Requests from the local serial target port.
    input wire reg_req_s rem_req, // Requests from the bidirectional control channel.
    input wire port_in_s [1:0] port_in, // Status and test bits of both receive ports.
    input wire logic strap_osc_pin, // Configuration pin choosing the test clock at startup.
    output reg_rsp_s loc_rsp_q, // Answer to the local port.
    output reg_rsp_s rem_rsp_q, // Answer to the control channel.
    output logic rem_busy_q, // High while a remote request waits; new ones are ignored.
    output logic selftest_req_q, // Self-test enable sent to the serializer.
    output logic test_clk_osc_q, // High selects the internal oscillator as test clock.
    output logic pclk_internal_q, // High drives the pixel clock from the link clock.
    output logic irq_pin_n_q // Interrupt pin, active low.
);
    // Access arbitration: local first, a colliding remote request waits until the local path is idle.
    logic pend_v_q;
    reg_req_s pend_q;
    wire loc_go = loc_req.rd | loc_req.wr;
    wire rem_go = (rem_req.rd | rem_req.wr) & ~pend_v_q;
    wire use_pend = ~loc_go & pend_v_q;
    wire use_rem = ~loc_go & ~pend_v_q & rem_go;
    wire reg_req_s acc = loc_go ? loc_req : (use_pend ? pend_q : rem_req);
    wire acc_go = loc_go | use_pend | use_rem;
    wire acc_rd = acc_go & acc.rd;
    wire acc_wr = acc_go & acc.wr;

    // Address match helper shared by the single-address decodes; the paged range uses its own compare.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // Paging and shared control registers.
    logic [7:0] page_q;
    logic [7:0] ictl_q;
    logic [7:0] cfg_q;
    logic [7:0] tm_q [2];
    wire rd_port = (page_q[5:4] == 2'b01); // RULE_09
    wire paged = (acc.addr >= `PAGED_LO && acc.addr <= `PAGED_HI)
        || (acc.addr[7:4] == 4'hd); // RULE_10
    wire wr_page = acc_wr && hit(acc.addr, `ADDR_PAGE_SEL);
    wire wr_ictl = acc_wr && hit(acc.addr, `ADDR_IRQ_CTRL);
    wire wr_cfg = acc_wr && hit(acc.addr, `ADDR_ST_CFG);
    wire rd_pri = acc_rd && hit(acc.addr, `ADDR_STS_PRI);
    wire rd_sec = acc_rd && hit(acc.addr, `ADDR_STS_SEC);

    // Strap pin passes three flops; the value is taken once two and three agree.
    // The fill count keeps the chain's reset zeros from being taken as the pin level.
    logic strap_s1_q, strap_s2_q, strap_s3_q, strap_done_q;
    logic [1:0] strap_fill_q;
    wire strap_ok = ~strap_done_q & (strap_fill_q == `STRAP_FILL_EDGES)
        & (strap_s2_q == strap_s3_q);

    // Per-port latched flags, source copies, self-test state.
    logic [1:0] crc_q, lchg_q, seq_q, par_q, enc_q, nclk_q;
    logic [1:0] lock_prev_q, pass_prev_q;
    logic [2:0] isr_lo_q [2];
    logic [2:0] isr_hi_q [2];
    logic [6:0] lfsr_q [2];
    logic [2:0] prime_q [2];
    logic [7:0] err_cnt_q [2];
    logic st_en_prev_q;
    logic [1:0] clr_pri, clr_sec, wr_en, lchg_ev, pchg_ev, miss_ev, port_assert;
    logic [1:0] pending;
    logic [1:0] bist_err;
    wire st_start = cfg_q[`ST_EN_BIT] & ~st_en_prev_q;
    wire cnt_clr = st_start | cfg_q[`ST_CLR_BIT];

    // Per-port decode of events, clears and write enables.
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            clr_pri[p] = rd_pri && (rd_port == p[0]); // RULE_12
            clr_sec[p] = rd_sec && (rd_port == p[0]); // RULE_18 RULE_19
            wr_en[p] = acc_wr && paged && page_q[p]; // RULE_09 RULE_22
            lchg_ev[p] = port_in[p].lock ^ lock_prev_q[p];
            pchg_ev[p] = port_in[p].pass ^ pass_prev_q[p];
            miss_ev[p] = port_in[p].clk_missing;
            port_assert[p] = |{isr_lo_q[p], isr_hi_q[p]};
            pending[p] = port_assert[p] & ictl_q[p]; // RULE_21
            bist_err[p] = cfg_q[`ST_EN_BIT] && port_in[p].rx_bit_valid
                && (prime_q[p] == `PRBS_PRIME_BITS)
                && ((lfsr_q[p][6] ^ lfsr_q[p][5] ^ tm_q[p][0]) != port_in[p].rx_bit); // RULE_06
        end
    end

    // Read data selection; the paged range shows the port chosen by the read select.
    wire [7:0] sts_pri = {1'b0, rd_port, crc_q[rd_port], lchg_q[rd_port], seq_q[rd_port],
        par_q[rd_port], port_in[rd_port].pass, port_in[rd_port].lock}; // RULE_16
    wire [7:0] sts_sec = {2'b00, enc_q[rd_port], 2'b00,
        port_in[rd_port].frequency_stable_flag, nclk_q[rd_port], 1'b0}; // RULE_17
    wire [7:0] gsts = {ictl_q[`IRQ_GLOBAL_BIT] & |pending, 5'h00, pending}; // RULE_21
    wire [7:0] rdata =
        hit(acc.addr, `ADDR_IRQ_CTRL) ? ictl_q :
        hit(acc.addr, `ADDR_IRQ_STATUS) ? gsts :
        hit(acc.addr, `ADDR_PAGE_SEL) ? page_q :
        hit(acc.addr, `ADDR_STS_PRI) ? sts_pri :
        hit(acc.addr, `ADDR_STS_SEC) ? sts_sec :
        hit(acc.addr, `ADDR_ERR_CNT) ? err_cnt_q[rd_port] : // RULE_07
        hit(acc.addr, `ADDR_ST_CFG) ? cfg_q :
        hit(acc.addr, `ADDR_TEST_MODE) ? tm_q[rd_port] :
        hit(acc.addr, `ADDR_ISR_HI) ? {5'h00, isr_hi_q[rd_port]} : // RULE_19
        hit(acc.addr, `ADDR_ISR_LO) ? {5'h00, isr_lo_q[rd_port]} : // RULE_18
        8'h00;

    // Arbitration state and answers to both access paths.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pend_v_q <= 1'b0;
            pend_q <= '0;
            loc_rsp_q <= '0;
            rem_rsp_q <= '0;
            rem_busy_q <= 1'b0;
        end
        else
        begin
            pend_v_q <= (loc_go & rem_go) | (pend_v_q & loc_go); // RULE_11
            if (loc_go & rem_go)
                pend_q <= rem_req;
            loc_rsp_q <= '{valid: loc_go, rdata: loc_go && loc_req.rd ? rdata : 8'h00};
            rem_rsp_q <= '{valid: use_pend | use_rem,
                rdata: (use_pend | use_rem) && acc.rd ? rdata : 8'h00}; // RULE_11
            rem_busy_q <= (loc_go & rem_go) | (pend_v_q & loc_go);
        end
    end

    // A buffered remote request is answered when served and the busy flag drops.
    a_pend_answer: assert property (@(posedge clock) disable iff (rst) // RULE_11
        use_pend |=> rem_rsp_q.valid && !rem_busy_q)
        else $error("buffered remote request not answered");
    // A direct remote request is answered on the next cycle.
    a_rem_answer: assert property (@(posedge clock) disable iff (rst) // RULE_11
        use_rem |=> rem_rsp_q.valid)
        else $error("remote request not answered next cycle");

    // Shared control registers, strap capture and self-test outputs.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            page_q <= `PAGE_SEL_RESET;
            ictl_q <= `IRQ_CTRL_RESET;
            cfg_q <= `ST_CFG_RESET;
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
            strap_s3_q <= 1'b0;
            strap_done_q <= 1'b0;
            strap_fill_q <= 2'd0;
            st_en_prev_q <= 1'b0;
            selftest_req_q <= 1'b0;
            test_clk_osc_q <= 1'b0;
            pclk_internal_q <= 1'b0;
            irq_pin_n_q <= 1'b1;
        end
        else
        begin
            strap_s1_q <= strap_osc_pin;
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
            strap_done_q <= strap_done_q | strap_ok;
            if (strap_fill_q != `STRAP_FILL_EDGES)
                strap_fill_q <= strap_fill_q + 2'd1;
            if (wr_page)
                page_q <= acc.wdata;
            if (wr_ictl)
                ictl_q <= acc.wdata;
            if (wr_cfg)
                cfg_q <= acc.wdata;
            else
            begin
                cfg_q[`ST_CLR_BIT] <= 1'b0; // RULE_13
                if (strap_ok)
                    cfg_q[`ST_OSC_BIT] <= strap_s3_q; // RULE_15
            end
            st_en_prev_q <= cfg_q[`ST_EN_BIT];
            selftest_req_q <= cfg_q[`ST_EN_BIT]; // RULE_01 RULE_03
            test_clk_osc_q <= cfg_q[`ST_OSC_BIT]; // RULE_02
            pclk_internal_q <= cfg_q[`ST_EN_BIT]; // RULE_08
            irq_pin_n_q <= ~(ictl_q[`IRQ_GLOBAL_BIT] & |pending); // RULE_20
        end
    end

    // The strap value reaches the clock select once the synchroniser has settled.
    a_strap_capture: assert property (@(posedge clock) disable iff (rst) // RULE_15
        strap_ok && !wr_cfg |=> cfg_q[`ST_OSC_BIT] == $past(strap_s3_q))
        else $error("strap value not captured");
    // Stopping the test drops the request and returns the pixel clock source.
    a_bist_stop: assert property (@(posedge clock) disable iff (rst) // RULE_01
        $fell(cfg_q[`ST_EN_BIT]) |=> !selftest_req_q && !pclk_internal_q)
        else $error("self-test request held after stop");
    // The interrupt pin stays high while the global enable is off.
    a_irq_global_off: assert property (@(posedge clock) disable iff (rst) // RULE_20
        !ictl_q[`IRQ_GLOBAL_BIT] |=> irq_pin_n_q)
        else $error("interrupt pin low with global enable off");
    // A page select write takes the written byte as it stands.
    a_page_write: assert property (@(posedge clock) disable iff (rst) // RULE_09
        wr_page |=> page_q == $past(acc.wdata))
        else $error("page select write lost");

    // Per-port flags: an event in the clearing cycle wins over the clear.
    always_ff @(posedge clock)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (rst)
            begin
                crc_q[p] <= 1'b0;
                lchg_q[p] <= 1'b0;
                seq_q[p] <= 1'b0;
                par_q[p] <= 1'b0;
                enc_q[p] <= 1'b0;
                nclk_q[p] <= 1'b0;
                lock_prev_q[p] <= 1'b0;
                pass_prev_q[p] <= 1'b0;
                isr_lo_q[p] <= 3'h0;
                isr_hi_q[p] <= 3'h0;
                tm_q[p] <= 8'h00;
            end
            else
            begin
                lock_prev_q[p] <= port_in[p].lock;
                pass_prev_q[p] <= port_in[p].pass;
                crc_q[p] <= port_in[p].crc_err | (crc_q[p] & ~clr_pri[p]); // RULE_12
                lchg_q[p] <= lchg_ev[p] | (lchg_q[p] & ~clr_pri[p]); // RULE_14
                seq_q[p] <= port_in[p].seq_err | (seq_q[p] & ~clr_pri[p]);
                par_q[p] <= port_in[p].parity_err | (par_q[p] & ~clr_pri[p]);
                enc_q[p] <= port_in[p].enc_err | (enc_q[p] & ~clr_sec[p]);
                nclk_q[p] <= miss_ev[p] | (nclk_q[p] & ~clr_sec[p]); // RULE_14
                isr_lo_q[p] <= {port_in[p].parity_err, pchg_ev[p], lchg_ev[p]}
                    | (isr_lo_q[p] & {3{~clr_sec[p]}}); // RULE_18
                isr_hi_q[p] <= {port_in[p].enc_err, port_in[p].seq_err, port_in[p].crc_err}
                    | (isr_hi_q[p] & {3{~clr_sec[p]}}); // RULE_19
                if (wr_en[p] && hit(acc.addr, `ADDR_TEST_MODE))
                    tm_q[p] <= acc.wdata; // RULE_10 RULE_22
            end
        end
    end

    // A lock change lands in both the latched flag and the low source copy.
    a_lock_change: assert property (@(posedge clock) disable iff (rst) // RULE_18
        lchg_ev[0] |=> lchg_q[0] && isr_lo_q[0][0])
        else $error("lock change not latched");
    // A secondary read clears the clock-missing flag unless a new event arrives.
    a_sec_clear: assert property (@(posedge clock) disable iff (rst) // RULE_17
        clr_sec[1] && !miss_ev[1] |=> !nclk_q[1])
        else $error("clock missing flag not cleared");
    // A write with only port 0 enabled leaves the port 1 test-mode copy alone.
    a_single_port: assert property (@(posedge clock) disable iff (rst) // RULE_09
        wr_en == 2'b01 |=> tm_q[1] == $past(tm_q[1]))
        else $error("port 1 copy written without its enable");

    // Self-test pattern tracking and saturating error counters.
    always_ff @(posedge clock)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (rst)
            begin
                lfsr_q[p] <= 7'h00;
                prime_q[p] <= 3'h0;
                err_cnt_q[p] <= 8'h00;
            end
            else
            begin
                if (st_start)
                    prime_q[p] <= 3'h0;
                else if (port_in[p].rx_bit_valid && prime_q[p] != `PRBS_PRIME_BITS)
                    prime_q[p] <= prime_q[p] + 3'h1;
                if (port_in[p].rx_bit_valid)
                    lfsr_q[p] <= {lfsr_q[p][5:0], port_in[p].rx_bit}; // RULE_06
                if (cnt_clr)
                    err_cnt_q[p] <= 8'h00;
                else if (bist_err[p] && err_cnt_q[p] != `ERR_CNT_MAX)
                    err_cnt_q[p] <= err_cnt_q[p] + 8'h01; // RULE_07
            end
        end
    end

    // Checks on the bank's own behaviour.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_irq_pin_gate: assert property (!irq_pin_n_q |-> $past(ictl_q[7]) && $past(|pending)) // RULE_20
        else $error("interrupt pin low without both enables");
    a_crc_set_wins: assert property (port_in[0].crc_err |=> crc_q[0]) // RULE_14
        else $error("crc event lost");
    a_pri_read_clear: assert property (rd_pri && !rd_port && !port_in[0].crc_err |=> !crc_q[0]) // RULE_12
        else $error("primary read did not clear crc flag");
    a_sec_isr_clear: assert property (clr_sec[1] && !port_in[1].enc_err |=> !isr_hi_q[1][2]) // RULE_19
        else $error("secondary read did not clear source bit");
    a_bist_request: assert property ($rose(cfg_q[0]) |=> selftest_req_q ##0 pclk_internal_q) // RULE_03
        else $error("self-test request or clock source late");
    a_sc_bit_drop: assert property (cfg_q[2] && !wr_cfg |=> !cfg_q[2] && err_cnt_q[0] == 8'h00) // RULE_13
        else $error("self-clearing bit stuck or counter not cleared");
    a_paged_both: assert property (wr_en == 2'b11 && hit(acc.addr, 8'hd0) |=> tm_q[0] == tm_q[1]) // RULE_22
        else $error("dual-port write did not reach both ports");
    a_loc_answer: assert property (loc_go |=> loc_rsp_q.valid) // RULE_11
        else $error("local request not answered next cycle");
    a_err_count: assert property (bist_err[1] && !cnt_clr && err_cnt_q[1] < 8'hff
        |=> err_cnt_q[1] == $past(err_cnt_q[1]) + 8'h01) // RULE_07
        else $error("error counter did not advance");
endmodule // rx_port_status_bist_regs

/* File: dv/serializer_model.sv */
// Far serializer model: streams the self-test pseudo-random sequence on one port.
`timescale 1ns/1ps
module serializer_model #(parameter int NB = 40)
(
    input wire logic clock, // System clock.
    input wire logic rst, // Synchronous reset.
    input wire logic test_en, // Self-test enable seen on the back channel.
    input wire logic slow, // High sends one bit every third cycle.
    output logic rx_bit, // Stream bit.
    output logic rx_bit_valid, // Qualifies rx_bit.
    output logic [7:0] bc_errors // Back-channel frames that failed their check.
);
    logic [6:0] lfsr_q;
    logic [7:0] sent_q;
    logic [1:0] gap_q;
    // Sends NB bits per enable; an idle data line toggles so stale data never looks valid.
    always_ff @(posedge clock)
    begin
        gap_q <= (gap_q == 2'd2 || !slow) ? 2'd0 : gap_q + 2'd1;
        rx_bit_valid <= 1'b0;
        rx_bit <= ~rx_bit;
        // Each cycle of the back channel is one frame; an enable that is not a clean level fails.
        if (!rst && $isunknown(test_en) && bc_errors != 8'hff)
            bc_errors <= bc_errors + 8'h01;
        if (rst)
        begin
            bc_errors <= 8'h00;
            lfsr_q <= 7'h7f;
            sent_q <= 8'h00;
            gap_q <= 2'd0;
            rx_bit <= 1'b0;
        end
        else if (!test_en)
            sent_q <= 8'h00;
        else if (sent_q < 8'(NB) && gap_q == 2'd0)
        begin
            rx_bit <= lfsr_q[6] ^ lfsr_q[5];
            rx_bit_valid <= 1'b1;
            lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
            sent_q <= sent_q + 8'h01;
        end
    end
endmodule // serializer_model

/* File: dv/tb.sv */
// Self-checking bench for the receive-port status and self-test register bank.
`timescale 1ns/1ps
`include "rx_status_cfg.svh"
module tb
    import rx_status_pkg::*;
;
    localparam int NB = 40;
    logic clock = 0, rst = 1, strap = 1;
    reg_req_s lreq = '0, rreq = '0;
    reg_rsp_s lrsp, rrsp;
    logic busy, streq, osc, pint, irqn;
    logic [7:0] lv [2] = '{8'h00, 8'h00};
    logic [7:0] ev [2] = '{8'h00, 8'h00};
    wire [1:0] rb, rv;
    wire [7:0] be0, be1;
    port_in_s [1:0] pin;
    byte_t lq [$], rq [$];
    int num_errors = 0, compares = 0, cyc = 0;
    integer seed = 32'h1d5f;
    logic [7:0] r;
    always #12.5 clock = ~clock;
    // Port inputs merge bench events with the model's stream.
    assign pin = {ev[1], rb[1], rv[1], ev[0], rb[0], rv[0]};
    rx_port_status_bist_regs DUT (.clock(clock), .rst(rst), .loc_req(lreq), .rem_req(rreq),
        .port_in(pin), .strap_osc_pin(strap), .loc_rsp_q(lrsp), .rem_rsp_q(rrsp),
        .rem_busy_q(busy), .selftest_req_q(streq), .test_clk_osc_q(osc),
        .pclk_internal_q(pint), .irq_pin_n_q(irqn));
    serializer_model #(.NB(NB)) m0 (.clock(clock), .rst(rst), .test_en(streq), .slow(1'b0),
        .rx_bit(rb[0]), .rx_bit_valid(rv[0]), .bc_errors(be0));
    serializer_model #(.NB(NB)) m1 (.clock(clock), .rst(rst), .test_en(streq), .slow(1'b1),
        .rx_bit(rb[1]), .rx_bit_valid(rv[1]), .bc_errors(be1));
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task end_sim;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One register access; the expected answer is queued for the monitor.
    task acc(input logic w, input byte_t a, input byte_t d, input byte_t e, input logic rem = 0);
        byte_t x;
        x = w ? 8'h00 : e;
        @(posedge clock);
        if (rem)
            rreq <= '{!w, w, a, d};
        else
            lreq <= '{!w, w, a, d};
        if (rem)
            rq.push_back(x);
        else
            lq.push_back(x);
        @(posedge clock);
        lreq <= '0;
        rreq <= '0;
    endtask
    task pulse(input int p, input logic [7:0] e);
        @(posedge clock);
        ev[p] <= lv[p] | e;
        @(posedge clock);
        ev[p] <= lv[p];
    endtask
    task idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Matches each answer with the oldest note and cuts a hang short.
    always @(posedge clock)
    begin
        if (lrsp.valid === 1'b1)
            chk("loc_rdata", lq.size() ? lq.pop_front() : 8'hxx, lrsp.rdata);
        if (rrsp.valid === 1'b1)
            chk("rem_rdata", rq.size() ? rq.pop_front() : 8'hxx, rrsp.rdata);
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            num_errors++;
            end_sim();
        end
    end
    // Main sequence.
    initial
    begin
        idle(3);
        rst <= 0;
        idle(8);
        acc(0, `ADDR_PAGE_SEL, 0, `PAGE_SEL_RESET);
        acc(0, `ADDR_ST_CFG, 0, 8'h02);
        acc(0, 8'h90, 0, 8'h00);
        chk("test_clk_osc", 8'h01, {7'h0, osc});
        $display("test reset done");
        r = 8'($random(seed)) | 8'h01;
        lv[0] = 8'h80;
        lv[1] = 8'h02;
        pulse(0, {2'b00, r[2], r[0], r[1], r[3], 1'b0, r[4]});
        pulse(1, 8'h05);
        acc(0, `ADDR_ISR_HI, 0, {5'h0, r[3], r[1], r[0]});
        acc(0, `ADDR_ISR_LO, 0, {5'h0, r[2], 2'b01});
        acc(1, `ADDR_IRQ_CTRL, 8'h01, 0);
        acc(0, `ADDR_IRQ_STATUS, 0, 8'h01);
        chk("irq_pin_n", 8'h01, {7'h0, irqn});
        acc(1, `ADDR_IRQ_CTRL, 8'h81, 0);
        idle(3);
        chk("irq_pin_n", 8'h00, {7'h0, irqn});
        acc(0, `ADDR_IRQ_STATUS, 0, 8'h81);
        acc(0, `ADDR_STS_PRI, 0, {2'b00, r[0], 1'b1, r[1], r[2], 2'b01});
        acc(0, `ADDR_STS_PRI, 0, 8'h01);
        acc(0, `ADDR_STS_SEC, 0, {2'b00, r[3], 3'b000, r[4], 1'b0});
        acc(0, `ADDR_ISR_LO, 0, 8'h00);
        idle(3);
        chk("irq_pin_n", 8'h01, {7'h0, irqn});
        acc(1, `ADDR_PAGE_SEL, 8'h10, 0);
        acc(0, `ADDR_STS_PRI, 0, 8'h40);
        acc(0, `ADDR_ISR_HI, 0, 8'h04);
        acc(0, `ADDR_STS_SEC, 0, 8'h26);
        acc(0, `ADDR_STS_SEC, 0, 8'h04);
        $display("test status done");
        acc(1, `ADDR_PAGE_SEL, 8'h03, 0);
        acc(1, `ADDR_TEST_MODE, 8'h01, 0);
        acc(1, `ADDR_PAGE_SEL, 8'h01, 0);
        acc(1, `ADDR_TEST_MODE, 8'h00, 0);
        acc(0, `ADDR_TEST_MODE, 0, 8'h00);
        acc(1, `ADDR_PAGE_SEL, 8'h12, 0);
        acc(0, `ADDR_TEST_MODE, 0, 8'h01);
        $display("test paging done");
        @(posedge clock);
        lreq <= '{1'b1, 1'b0, `ADDR_PAGE_SEL, 8'h00};
        rreq <= '{1'b0, 1'b1, `ADDR_ST_CFG, 8'h03};
        lq.push_back(8'h12);
        rq.push_back(8'h00);
        @(posedge clock);
        lreq <= '0;
        rreq <= '0;
        @(negedge clock);
        chk("rem_busy", 8'h01, {7'h0, busy});
        acc(0, `ADDR_ST_CFG, 0, 8'h03, 1);
        idle(3);
        chk("selftest_req", 8'h01, {7'h0, streq});
        chk("pclk_internal", 8'h01, {7'h0, pint});
        $display("test remote done");
        idle(3 * NB + 20);
        acc(1, `ADDR_PAGE_SEL, 8'h00, 0);
        acc(0, `ADDR_ERR_CNT, 0, 8'h00);
        acc(1, `ADDR_PAGE_SEL, 8'h10, 0);
        acc(0, `ADDR_ERR_CNT, 0, 8'(NB - 7));
        acc(1, `ADDR_ST_CFG, 8'h07, 0);
        acc(0, `ADDR_ST_CFG, 0, 8'h03);
        acc(0, `ADDR_ERR_CNT, 0, 8'h00);
        acc(1, `ADDR_ST_CFG, 8'h02, 0);
        idle(3);
        chk("selftest_req", 8'h00, {7'h0, streq});
        chk("pclk_internal", 8'h00, {7'h0, pint});
        $display("test selftest done");
        idle(4);
        chk("unanswered", 8'h00, 8'(lq.size() + rq.size()));
        chk("back_channel0", 8'h00, be0);
        chk("back_channel1", 8'h00, be1);
        end_sim();
    end
endmodule // tb
